//--- src/osr_pkg.sv
// Package for the oscillator subsystem output configuration bank
package osr_pkg;
    // Forwarding word fields
    localparam int ID_LSB = 0;
    localparam int ID_W = 3;
    localparam int ADDR_LSB = 3;
    localparam int ADDR_W = 4;
    localparam int DATA_LSB = 7;
    localparam int DATA_W = 9;
    localparam int FWD_W = 17;
    // Subsystem register addresses
    localparam logic [3:0] ADDR_ENABLES = 4'h1;
    localparam logic [3:0] ADDR_OUTPUT_DIVIDER_GAIN = 4'h2;
    localparam logic [3:0] ADDR_OUTPUT_CONFIG = 4'h3;
    localparam logic [3:0] ADDR_CAL_BIAS_SETTINGS = 4'h4;
    localparam logic [3:0] ADDR_COARSE_CAL_SETTINGS = 4'h5;
    localparam logic [3:0] ADDR_MSB_CAL_SETTINGS = 4'h6;
    // Reset values
    localparam logic [8:0] RST_ENABLES = 9'h01f;
    localparam logic [8:0] RST_OUTPUT_DIVIDER_GAIN = 9'h0c1;
    localparam logic [8:0] RST_OUTPUT_CONFIG = 9'h041;
    localparam logic [8:0] RST_CAL_BIAS_SETTINGS = 9'h0c9;
    localparam logic [8:0] RST_COARSE_CAL_SETTINGS = 9'h0aa;
    localparam logic [8:0] RST_MSB_CAL_SETTINGS = 9'h0ff;
    // Field positions
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 6;
    localparam int GAIN_LSB = 6;
    localparam int GAIN_W = 2;
    localparam int DIVGAIN_BIT = 8;
    localparam int FUND_BIT = 0;
    localparam int MANUAL_BIT = 2;
    localparam int BUFBIAS_LSB = 3;
    localparam int MASTER_BIT = 0;
    localparam int EN_SYNTH_BUF_BIT = 1;
    localparam int EN_OUT_BUF_BIT = 2;
    localparam int EN_DIV1_BIT = 3;
    localparam int EN_DIVIDER_BIT = 4;
    localparam logic [5:0] DIV_MAX = 6'h3e;
    localparam logic [5:0] DIV_MUTE = 6'h00;
    localparam logic [5:0] DIV_ONE = 6'h01;
endpackage : osr_pkg

//--- src/osr_wr_if.sv
// Interface carrying one decoded subsystem register write
`timescale 1ns/1ps
`default_nettype none
interface osr_wr_if;
    logic wr;
    logic [3:0] addr;
    logic [8:0] data;
    modport src (output wr, output addr, output data);
    modport dst (input wr, input addr, input data);
endinterface : osr_wr_if
`default_nettype wire

//--- src/osr_reg9.sv
// One 9-bit write-only subsystem register
`timescale 1ns/1ps
`default_nettype none
module osr_reg9 #(
    parameter logic [3:0] ADDR = 4'h0,
    parameter logic [8:0] RST = 9'h000
) (
    input wire logic sys_clk,
    input wire logic rst,
    osr_wr_if.dst wr_bus,
    output logic [8:0] q
);
    logic [8:0] q_ff;
    logic [8:0] nxt_q;

    // Load only when this address is selected
    always_comb begin
        nxt_q = q_ff;
        if (wr_bus.wr && (wr_bus.addr == ADDR)) begin
            nxt_q = wr_bus.data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_ff <= RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;

    property p_upd;
        @(posedge sys_clk) disable iff (rst)
        wr_bus.wr && wr_bus.addr == ADDR |=> q_ff == $past(wr_bus.data);
    endproperty
    a_upd: assert property (p_upd) else $error("addressed register did not load");
    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        !(wr_bus.wr && wr_bus.addr == ADDR) |=> $stable(q_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("unaddressed register changed");
endmodule : osr_reg9
`default_nettype wire

//--- src/osr_output_cfg.sv
// Oscillator subsystem output configuration bank, fed by forwarded writes
`timescale 1ns/1ps
`default_nettype none
module osr_output_cfg #(
    parameter logic [2:0] SUBSYS_ID = 3'h0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fwd_wr,
    input wire logic [16:0] fwd_word,
    output logic synth_buf_en,
    output logic out_buf_en,
    output logic div1_en,
    output logic divider_en,
    output logic [5:0] divide_ratio,
    output logic [1:0] out_gain,
    output logic div_stage_gain_max,
    output logic fundamental_mode,
    output logic [1:0] out_buf_bias,
    output logic [8:0] cal_bias,
    output logic [8:0] coarse_cal,
    output logic [8:0] top_cal
);
    osr_wr_if wr_bus ();
    logic [8:0] en_q;
    logic [8:0] divg_q;
    logic [8:0] cfg_q;
    logic [8:0] calb_q;
    logic [8:0] cf_q;
    logic [8:0] msb_q;
    logic [5:0] eff_div;
    logic manual_mode;

    // Decode of the forwarded word; write-only, so there is no read path
    assign wr_bus.wr = fwd_wr && (fwd_word[osr_pkg::ID_LSB +: osr_pkg::ID_W] == SUBSYS_ID);
    assign wr_bus.addr = fwd_word[osr_pkg::ADDR_LSB +: osr_pkg::ADDR_W];
    assign wr_bus.data = fwd_word[osr_pkg::DATA_LSB +: osr_pkg::DATA_W];

    // Enables register, kept so manual mode has its local enables
    osr_reg9 #(.ADDR(osr_pkg::ADDR_ENABLES), .RST(osr_pkg::RST_ENABLES)) u_en (
        .sys_clk(sys_clk), .rst(rst), .wr_bus(wr_bus), .q(en_q));
    osr_reg9 #(.ADDR(osr_pkg::ADDR_OUTPUT_DIVIDER_GAIN), .RST(osr_pkg::RST_OUTPUT_DIVIDER_GAIN))
        u_divg (.sys_clk(sys_clk), .rst(rst), .wr_bus(wr_bus), .q(divg_q));
    osr_reg9 #(.ADDR(osr_pkg::ADDR_OUTPUT_CONFIG), .RST(osr_pkg::RST_OUTPUT_CONFIG)) u_cfg (
        .sys_clk(sys_clk), .rst(rst), .wr_bus(wr_bus), .q(cfg_q));
    osr_reg9 #(.ADDR(osr_pkg::ADDR_CAL_BIAS_SETTINGS), .RST(osr_pkg::RST_CAL_BIAS_SETTINGS))
        u_calb (.sys_clk(sys_clk), .rst(rst), .wr_bus(wr_bus), .q(calb_q));
    osr_reg9 #(.ADDR(osr_pkg::ADDR_COARSE_CAL_SETTINGS), .RST(osr_pkg::RST_COARSE_CAL_SETTINGS))
        u_cf (.sys_clk(sys_clk), .rst(rst), .wr_bus(wr_bus), .q(cf_q));
    osr_reg9 #(.ADDR(osr_pkg::ADDR_MSB_CAL_SETTINGS), .RST(osr_pkg::RST_MSB_CAL_SETTINGS))
        u_msb (.sys_clk(sys_clk), .rst(rst), .wr_bus(wr_bus), .q(msb_q));

    assign manual_mode = cfg_q[osr_pkg::MANUAL_BIT];

    // Fold the raw divide code to a legal ratio
    always_comb begin
        eff_div = divg_q[osr_pkg::DIV_LSB +: osr_pkg::DIV_W];
        if (manual_mode) begin
            eff_div[0] = 1'b0;
        end
        if (eff_div > osr_pkg::DIV_MAX) begin
            eff_div = osr_pkg::DIV_MAX;
        end else if (eff_div > osr_pkg::DIV_ONE) begin
            eff_div[0] = 1'b0;
        end
    end

    // Output state registers
    logic synth_buf_en_ff, nxt_synth_buf_en;
    logic out_buf_en_ff, nxt_out_buf_en;
    logic div1_en_ff, nxt_div1_en;
    logic divider_en_ff, nxt_divider_en;
    logic [5:0] divide_ratio_ff, nxt_divide_ratio;
    logic [1:0] out_gain_ff, nxt_out_gain;
    logic div_stage_gain_max_ff, nxt_div_stage_gain_max;
    logic fundamental_mode_ff, nxt_fundamental_mode;
    logic [1:0] out_buf_bias_ff, nxt_out_buf_bias;
    logic [8:0] cal_bias_ff, nxt_cal_bias;
    logic [8:0] coarse_cal_ff, nxt_coarse_cal;
    logic [8:0] top_cal_ff, nxt_top_cal;

    // Enable steering; registered one cycle after the stored settings
    always_comb begin
        nxt_divide_ratio = eff_div;
        nxt_out_gain = divg_q[osr_pkg::GAIN_LSB +: osr_pkg::GAIN_W];
        nxt_div_stage_gain_max = divg_q[osr_pkg::DIVGAIN_BIT];
        nxt_fundamental_mode = cfg_q[osr_pkg::FUND_BIT];
        // Bias values are passed as written; the host owns their correctness
        nxt_out_buf_bias = cfg_q[osr_pkg::BUFBIAS_LSB +: 2];
        nxt_cal_bias = calb_q;
        nxt_coarse_cal = cf_q;
        nxt_top_cal = msb_q;
        if (!en_q[osr_pkg::MASTER_BIT]) begin
            nxt_synth_buf_en = 1'b0;
            nxt_out_buf_en = 1'b0;
            nxt_div1_en = 1'b0;
            nxt_divider_en = 1'b0;
        end else if (manual_mode) begin
            nxt_synth_buf_en = en_q[osr_pkg::EN_SYNTH_BUF_BIT];
            nxt_out_buf_en = en_q[osr_pkg::EN_OUT_BUF_BIT];
            nxt_div1_en = en_q[osr_pkg::EN_DIV1_BIT];
            nxt_divider_en = en_q[osr_pkg::EN_DIVIDER_BIT];
        end else begin
            nxt_synth_buf_en = 1'b1;
            nxt_out_buf_en = (eff_div != osr_pkg::DIV_MUTE);
            nxt_div1_en = (eff_div == osr_pkg::DIV_ONE);
            nxt_divider_en = (eff_div > osr_pkg::DIV_ONE);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            synth_buf_en_ff <= 1'b0;
            out_buf_en_ff <= 1'b0;
            div1_en_ff <= 1'b0;
            divider_en_ff <= 1'b0;
            divide_ratio_ff <= osr_pkg::RST_OUTPUT_DIVIDER_GAIN[5:0];
            out_gain_ff <= osr_pkg::RST_OUTPUT_DIVIDER_GAIN[7:6];
            div_stage_gain_max_ff <= osr_pkg::RST_OUTPUT_DIVIDER_GAIN[8];
            fundamental_mode_ff <= osr_pkg::RST_OUTPUT_CONFIG[0];
            out_buf_bias_ff <= osr_pkg::RST_OUTPUT_CONFIG[4:3];
            cal_bias_ff <= osr_pkg::RST_CAL_BIAS_SETTINGS;
            coarse_cal_ff <= osr_pkg::RST_COARSE_CAL_SETTINGS;
            top_cal_ff <= osr_pkg::RST_MSB_CAL_SETTINGS;
        end else begin
            synth_buf_en_ff <= nxt_synth_buf_en;
            out_buf_en_ff <= nxt_out_buf_en;
            div1_en_ff <= nxt_div1_en;
            divider_en_ff <= nxt_divider_en;
            divide_ratio_ff <= nxt_divide_ratio;
            out_gain_ff <= nxt_out_gain;
            div_stage_gain_max_ff <= nxt_div_stage_gain_max;
            fundamental_mode_ff <= nxt_fundamental_mode;
            out_buf_bias_ff <= nxt_out_buf_bias;
            cal_bias_ff <= nxt_cal_bias;
            coarse_cal_ff <= nxt_coarse_cal;
            top_cal_ff <= nxt_top_cal;
        end
    end

    assign synth_buf_en = synth_buf_en_ff;
    assign out_buf_en = out_buf_en_ff;
    assign div1_en = div1_en_ff;
    assign divider_en = divider_en_ff;
    assign divide_ratio = divide_ratio_ff;
    assign out_gain = out_gain_ff;
    assign div_stage_gain_max = div_stage_gain_max_ff;
    assign fundamental_mode = fundamental_mode_ff;
    assign out_buf_bias = out_buf_bias_ff;
    assign cal_bias = cal_bias_ff;
    assign coarse_cal = coarse_cal_ff;
    assign top_cal = top_cal_ff;

    // Checks on the steering
    // Sampled rst keeps the release edge quiet: enable flops still hold reset there
    sequence s_auto_on;
        !rst && en_q[osr_pkg::MASTER_BIT] && !manual_mode;
    endsequence
    property p_master_off;
        @(posedge sys_clk) disable iff (rst)
        !en_q[osr_pkg::MASTER_BIT] |=> !synth_buf_en && !out_buf_en && !div1_en && !divider_en;
    endproperty
    a_master_off: assert property (p_master_off) else $error("blocks on with master off");
    property p_mute;
        @(posedge sys_clk) disable iff (rst)
        s_auto_on and (eff_div == osr_pkg::DIV_MUTE) |=> synth_buf_en && !out_buf_en;
    endproperty
    a_mute: assert property (p_mute) else $error("mute did not gate output");
    property p_auto_div1;
        @(posedge sys_clk) disable iff (rst)
        s_auto_on |=> div1_en == ($past(divg_q[5:0]) == osr_pkg::DIV_ONE);
    endproperty
    a_auto_div1: assert property (p_auto_div1) else $error("pass path enable wrong");
    property p_fold;
        @(posedge sys_clk) disable iff (rst)
        !manual_mode && divg_q[5:0] > osr_pkg::DIV_MAX |=> divide_ratio == osr_pkg::DIV_MAX;
    endproperty
    a_fold: assert property (p_fold) else $error("high code not clamped");
    property p_even;
        @(posedge sys_clk) disable iff (rst)
        divg_q[5:0] > osr_pkg::DIV_ONE |=> !divide_ratio[0];
    endproperty
    a_even: assert property (p_even) else $error("odd ratio produced");
    property p_manual_lsb;
        @(posedge sys_clk) disable iff (rst)
        manual_mode |=> !divide_ratio[0];
    endproperty
    a_manual_lsb: assert property (p_manual_lsb) else $error("lsb used in manual mode");
    property p_manual_en;
        @(posedge sys_clk) disable iff (rst)
        en_q[0] && manual_mode |=> out_buf_en == $past(en_q[osr_pkg::EN_OUT_BUF_BIT]);
    endproperty
    a_manual_en: assert property (p_manual_en) else $error("manual enable ignored");
    property p_id_filter;
        @(posedge sys_clk) disable iff (rst)
        fwd_wr && fwd_word[2:0] != SUBSYS_ID |=> ##1 $stable(out_gain);
    endproperty
    a_id_filter: assert property (p_id_filter) else $error("foreign id write took effect");
    property p_gain_path;
        @(posedge sys_clk) disable iff (rst)
        wr_bus.wr && wr_bus.addr == osr_pkg::ADDR_OUTPUT_DIVIDER_GAIN
            |=> ##1 out_gain == $past(wr_bus.data[7:6], 2);
    endproperty
    a_gain_path: assert property (p_gain_path) else $error("gain not applied");
    property p_fund;
        @(posedge sys_clk) disable iff (rst)
        wr_bus.wr && wr_bus.addr == osr_pkg::ADDR_OUTPUT_CONFIG
            |=> ##1 fundamental_mode == $past(wr_bus.data[0], 2);
    endproperty
    a_fund: assert property (p_fund) else $error("mode select not applied");
    // Steps of automatic and manual steering and of the write paths
    sequence s_manual_on;
        !rst && en_q[osr_pkg::MASTER_BIT] && manual_mode;
    endsequence
    sequence s_take_divg;
        wr_bus.wr && wr_bus.addr == osr_pkg::ADDR_OUTPUT_DIVIDER_GAIN;
    endsequence
    sequence s_take_cfg;
        wr_bus.wr && wr_bus.addr == osr_pkg::ADDR_OUTPUT_CONFIG;
    endsequence
    sequence s_take_cal;
        wr_bus.wr && wr_bus.addr == osr_pkg::ADDR_CAL_BIAS_SETTINGS;
    endsequence
    sequence s_take_coarse;
        wr_bus.wr && wr_bus.addr == osr_pkg::ADDR_COARSE_CAL_SETTINGS;
    endsequence
    sequence s_take_top;
        wr_bus.wr && wr_bus.addr == osr_pkg::ADDR_MSB_CAL_SETTINGS;
    endsequence
    property p_auto_synth;
        @(posedge sys_clk) disable iff (rst)
        s_auto_on |=> synth_buf_en;
    endproperty
    a_auto_synth: assert property (p_auto_synth) else $error("synth buffer off in auto");
    property p_auto_out;
        @(posedge sys_clk) disable iff (rst)
        s_auto_on |=> out_buf_en == ($past(eff_div) != osr_pkg::DIV_MUTE);
    endproperty
    a_auto_out: assert property (p_auto_out) else $error("output buffer enable wrong");
    property p_auto_divider;
        @(posedge sys_clk) disable iff (rst)
        s_auto_on |=> divider_en == ($past(eff_div) > osr_pkg::DIV_ONE);
    endproperty
    a_auto_divider: assert property (p_auto_divider) else $error("divider enable wrong");
    property p_manual_synth;
        @(posedge sys_clk) disable iff (rst)
        s_manual_on |=> synth_buf_en == $past(en_q[osr_pkg::EN_SYNTH_BUF_BIT]);
    endproperty
    a_manual_synth: assert property (p_manual_synth) else $error("manual synth enable");
    property p_manual_div1;
        @(posedge sys_clk) disable iff (rst)
        s_manual_on |=> div1_en == $past(en_q[osr_pkg::EN_DIV1_BIT]);
    endproperty
    a_manual_div1: assert property (p_manual_div1) else $error("manual pass enable");
    property p_manual_divider;
        @(posedge sys_clk) disable iff (rst)
        s_manual_on |=> divider_en == $past(en_q[osr_pkg::EN_DIVIDER_BIT]);
    endproperty
    a_manual_divider: assert property (p_manual_divider) else $error("manual divider");
    property p_ratio_path;
        @(posedge sys_clk) disable iff (rst)
        !rst |=> divide_ratio == $past(eff_div);
    endproperty
    a_ratio_path: assert property (p_ratio_path) else $error("ratio not registered");
    property p_manual_mode;
        @(posedge sys_clk) disable iff (rst)
        s_take_cfg |=> manual_mode == $past(wr_bus.data[osr_pkg::MANUAL_BIT]);
    endproperty
    a_manual_mode: assert property (p_manual_mode) else $error("mode bit not stored");
    property p_stage_gain;
        @(posedge sys_clk) disable iff (rst)
        s_take_divg |=> ##1 div_stage_gain_max == $past(wr_bus.data[osr_pkg::DIVGAIN_BIT], 2);
    endproperty
    a_stage_gain: assert property (p_stage_gain) else $error("stage gain not applied");
    property p_bias_path;
        @(posedge sys_clk) disable iff (rst)
        s_take_cfg |=> ##1 out_buf_bias == $past(wr_bus.data[4:3], 2);
    endproperty
    a_bias_path: assert property (p_bias_path) else $error("bias not applied");
    property p_cal_path;
        @(posedge sys_clk) disable iff (rst)
        s_take_cal |=> ##1 cal_bias == $past(wr_bus.data, 2);
    endproperty
    a_cal_path: assert property (p_cal_path) else $error("cal bias not applied");
    property p_coarse_path;
        @(posedge sys_clk) disable iff (rst)
        s_take_coarse |=> ##1 coarse_cal == $past(wr_bus.data, 2);
    endproperty
    a_coarse_path: assert property (p_coarse_path) else $error("coarse cal not applied");
    property p_top_path;
        @(posedge sys_clk) disable iff (rst)
        s_take_top |=> ##1 top_cal == $past(wr_bus.data, 2);
    endproperty
    a_top_path: assert property (p_top_path) else $error("top cal not applied");
endmodule : osr_output_cfg
`default_nettype wire

//--- verif/osr_host_model.sv
// Host model that forwards writes to the oscillator subsystem bank
`timescale 1ns/1ps
`default_nettype none
module osr_host_model (
    input wire logic sys_clk,
    output var logic fwd_wr,
    output var logic [16:0] fwd_word
);
    // Registers are write-only, so the host keeps its own copy
    logic [8:0] shadow [0:15];
    initial begin
        fwd_wr = 1'b0;
        fwd_word = 17'h00000;
    end
    // One-cycle pulse; the idle word is inverted so stale data never looks valid
    task automatic send(input logic [2:0] id, input logic [3:0] addr, input logic [8:0] data);
        @(posedge sys_clk);
        fwd_wr <= 1'b1;
        fwd_word <= {1'b0, data, addr, id};
        shadow[addr] = data;
        @(posedge sys_clk);
        fwd_wr <= 1'b0;
        fwd_word <= ~{1'b0, data, addr, id};
    endtask : send
    // Config word: bias 10 in fundamental mode, 00 in doubler mode, spare kept at 2
    function automatic logic [8:0] mode_word(input logic fund, input logic manual);
        return {4'h2, (fund ? 2'b10 : 2'b00), manual, 1'b0, fund};
    endfunction : mode_word
    // Only the supported calibration and bias values are ever loaded
    function automatic logic [8:0] cal_word(input logic [3:0] addr);
        case (addr)
            4'h4: return 9'h0c1;
            4'h5: return 9'h02c;
            default: return 9'h0ff;
        endcase
    endfunction : cal_word
endmodule : osr_host_model
`default_nettype wire

//--- verif/osr_output_cfg_bench.sv
// Self-checking bench for the oscillator subsystem output configuration bank
`timescale 1ns/1ps
`default_nettype none
module osr_output_cfg_bench;
    logic sys_clk, rst, fwd_wr;
    logic [16:0] fwd_word;
    logic synth_buf_en, out_buf_en, div1_en, divider_en, div_stage_gain_max, fundamental_mode;
    logic [5:0] divide_ratio;
    logic [1:0] out_gain, out_buf_bias;
    logic [8:0] cal_bias, coarse_cal, top_cal;
    logic [5:0] codes [0:8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h3d, 6'h3e, 6'h3f};
    logic [5:0] r;
    int err_count = 0;
    int n_tests = 0;
    osr_output_cfg #(.SUBSYS_ID(3'h0)) i_dut (.sys_clk(sys_clk), .rst(rst), .fwd_wr(fwd_wr),
        .fwd_word(fwd_word), .synth_buf_en(synth_buf_en), .out_buf_en(out_buf_en),
        .div1_en(div1_en), .divider_en(divider_en), .divide_ratio(divide_ratio),
        .out_gain(out_gain), .div_stage_gain_max(div_stage_gain_max),
        .fundamental_mode(fundamental_mode), .out_buf_bias(out_buf_bias),
        .cal_bias(cal_bias), .coarse_cal(coarse_cal), .top_cal(top_cal));
    osr_host_model i_host (.sys_clk(sys_clk), .fwd_wr(fwd_wr), .fwd_word(fwd_word));
    // Verdict in one place
    task automatic summarize();
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Enables as {synth buffer, output buffer, divide-by-one, divider}
    task automatic chk_en(input logic [3:0] exp);
        chk({5'h00, synth_buf_en, out_buf_en, div1_en, divider_en}, {5'h00, exp}, "enables");
    endtask : chk_en
    // Outputs settle one edge after the taken edge; the task waits two edges
    task automatic wr(input logic [2:0] id, input logic [3:0] a, input logic [8:0] d);
        i_host.send(id, a, d);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : wr
    // Odd codes above 1 fold down, anything past 62 clamps
    function automatic logic [5:0] fold(input logic [5:0] c);
        if (c > 6'h3e) return 6'h3e;
        if (c == 6'h01) return 6'h01;
        return c & 6'h3e;
    endfunction : fold
    function automatic logic [3:0] auto_en(input logic [5:0] f);
        return (f == 6'h00) ? 4'h8 : ((f == 6'h01) ? 4'he : 4'hd);
    endfunction : auto_en
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Watchdog well past the expected run of about a hundred cycles
    initial begin
        #200000;
        err_count++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        // Reset state
        chk(divide_ratio, 9'h001, "rst div");
        chk(out_gain, 9'h003, "rst gain");
        chk(div_stage_gain_max, 9'h000, "rst stage");
        chk(fundamental_mode, 9'h001, "rst fund");
        chk(out_buf_bias, 9'h000, "rst bias");
        chk(cal_bias, 9'h0c9, "rst cal");
        chk_en(4'he);
        // Every divide code class, stepping the gain code through all four values
        for (int i = 0; i < 9; i++) begin
            wr(3'h0, osr_pkg::ADDR_OUTPUT_DIVIDER_GAIN, {i[0], i[1:0], codes[i]});
            r = fold(codes[i]);
            chk(divide_ratio, r, "ratio");
            chk_en(auto_en(r));
            chk(out_gain, i[1:0], "gain");
            chk(div_stage_gain_max, i[0], "stage gain");
        end
        chk(cal_bias, 9'h0c9, "untouched");
        // Wrong id and unmapped addresses are ignored
        wr(3'h1, osr_pkg::ADDR_OUTPUT_DIVIDER_GAIN, 9'h004);
        chk(divide_ratio, 9'h03e, "wrong id");
        wr(3'h0, 4'h0, 9'h004);
        wr(3'h0, 4'h7, 9'h004);
        chk(divide_ratio, 9'h03e, "bad addr");
        for (int a = 4; a < 7; a++) begin
            wr(3'h0, a[3:0], i_host.cal_word(a[3:0]));
        end
        chk(cal_bias, 9'h0c1, "cal");
        chk(coarse_cal, 9'h02c, "coarse");
        chk(top_cal, 9'h0ff, "top");
        // Write-only bank: the host copy is the only record of what was loaded
        chk(cal_bias, i_host.shadow[4], "shadow");
        // Local enables have no say in automatic mode
        wr(3'h0, osr_pkg::ADDR_ENABLES, 9'h015);
        chk_en(4'hd);
        wr(3'h0, osr_pkg::ADDR_OUTPUT_CONFIG, i_host.mode_word(1'b1, 1'b1));
        chk_en(4'h5);
        chk(out_buf_bias, 9'h002, "bias");
        wr(3'h0, osr_pkg::ADDR_OUTPUT_DIVIDER_GAIN, 9'h003);
        chk(divide_ratio, 9'h002, "manual lsb");
        wr(3'h0, osr_pkg::ADDR_OUTPUT_DIVIDER_GAIN, 9'h001);
        chk(divide_ratio, 9'h000, "manual one");
        // Master off wins in either mode
        wr(3'h0, osr_pkg::ADDR_ENABLES, 9'h01e);
        chk_en(4'h0);
        wr(3'h0, osr_pkg::ADDR_OUTPUT_CONFIG, i_host.mode_word(1'b0, 1'b0));
        chk_en(4'h0);
        chk(fundamental_mode, 9'h000, "doubler");
        chk(out_buf_bias, 9'h000, "bias dbl");
        wr(3'h0, osr_pkg::ADDR_ENABLES, 9'h01f);
        chk_en(4'he);
        summarize();
    end
endmodule : osr_output_cfg_bench
`default_nettype wire
